// ### src/pcs_press_cam_supervisor.v
// Press crank cam supervisor with AHB-Lite register slave
`timescale 1ns/1ps
`include "pcs_regs.vh"
module pcs_press_cam_supervisor #(
  parameter W = 16
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  input  wire [W-1:0]  position,
  input  wire          pressRunRequest,
  input  wire          camResetIn,
  input  wire          setupMode,
  input  wire          reversePermission,
  input  wire          upwardCamInput,
  input  wire          overrunCamInput,
  output reg           monitorOk,
  output reg           topDeadCentreFlag,
  output reg           bottomDeadCentreFlag,
  output reg           upwardStrokeFlag,
  output reg           forwardMotionFlag,
  output reg           reverseMotionFlag,
  output reg           standstillFlag,
  output reg  [W-1:0]  topOverrunDistance,
  output reg  [W-1:0]  stopOverrunDistance,
  output reg           irq
);

  // Wrap-aware window test
  function inWin;
    input [W-1:0] p;
    input [W-1:0] lo;
    input [W-1:0] hi;
    begin
      if (lo <= hi)
        inWin = (p >= lo) && (p <= hi);
      else
        inWin = (p >= lo) || (p <= hi);
    end
  endfunction

  // Shortest way round: bit W is the counter-clockwise sign
  function [W:0] turnDelta;
    input [W-1:0] now;
    input [W-1:0] base;
    input [W-1:0] full;
    reg   [W:0]   span;
    reg   [W:0]   fwd;
    begin
      span = {1'b0, full} + {{W{1'b0}}, 1'b1};
      if (now >= base)
        fwd = {1'b0, now} - {1'b0, base};
      else
        fwd = {1'b0, now} + span - {1'b0, base};
      if ((fwd << 1) <= span)
        turnDelta = {1'b0, fwd[W-1:0]};
      else
        turnDelta = {1'b1, span[W-1:0] - fwd[W-1:0]};
    end
  endfunction

  // Errors never signalled; held in a flop so every output is registered
  always @(posedge clock or posedge rst) begin
    if (rst)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // Pin synchronisers; multi-bit position assumed quasi-static per frame
  reg [W-1:0] posMeta_q, pos_q;
  reg [5:0]   pinMeta_q, pin_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      posMeta_q <= {W{1'b0}};
      pos_q     <= {W{1'b0}};
      pinMeta_q <= 6'h00;
      pin_q     <= 6'h00;
    end else begin
      posMeta_q <= position;
      pos_q     <= posMeta_q;
      pinMeta_q <= {overrunCamInput, upwardCamInput, reversePermission,
                    setupMode, camResetIn, pressRunRequest};
      pin_q     <= pinMeta_q;
    end
  end
  wire runReq  = pin_q[0];
  wire camRst  = pin_q[1];
  wire setupIn = pin_q[2];

  reg run_q, camRst_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      run_q    <= 1'b0;
      camRst_q <= 1'b0;
    end else begin
      run_q    <= runReq;
      camRst_q <= camRst;
    end
  end
  wire runRise = runReq & ~run_q;
  wire runFall = ~runReq & run_q;
  wire rstFall = ~camRst & camRst_q;

  // Register file
  reg [1:0]   ctrl_q;
  reg [W-1:0] jitter_q, stillCyc_q, moveCyc_q, startCyc_q;
  reg [W-1:0] minDelta_q, fullTurn_q;
  reg [W-1:0] stage_q [0:`PCS_LIM_COUNT-1];
  reg [W-1:0] lim_q   [0:`PCS_LIM_COUNT-1];
  reg [`PCS_IRQ_BITS-1:0] irqSts_q, irqEn_q;

  wire pendulum  = ctrl_q[`PCS_CTRL_PENDULUM];
  wire excentric = ctrl_q[`PCS_CTRL_EXCENTRIC] & ~pendulum;

  // Bus address and data phase tracking
  reg        wrPend_q, rdPend_q;
  reg [7:0]  addr_q;
  wire       accept = hsel & htrans[1] & hready;
  wire       wrEn   = wrPend_q;
  wire [7:0] limOff = addr_q - `PCS_OFF_LIM_BASE;
  wire       limHit = (addr_q >= `PCS_OFF_LIM_BASE) &&
                      (addr_q < `PCS_OFF_TOP_OVR);
  wire [2:0] limIdx = limOff[4:2];

  reg [`PCS_IRQ_BITS-1:0] irqEvt;
  reg [`PCS_IRQ_BITS-1:0] irqClr;
  integer i;
  integer j;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPend_q  <= 1'b0;
      rdPend_q  <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
    end else begin
      wrPend_q <= accept & hwrite;
      rdPend_q <= accept & ~hwrite;
      if (accept)
        addr_q <= haddr[7:0];
      // Reads take one wait state so a write just before is visible
      hreadyout <= ~(accept & ~hwrite);
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q     <= `PCS_RST_CTRL;
      jitter_q   <= `PCS_RST_JITTER;
      stillCyc_q <= `PCS_RST_STILL_CYC;
      moveCyc_q  <= `PCS_RST_MOVE_CYC;
      startCyc_q <= `PCS_RST_START_CYC;
      minDelta_q <= `PCS_RST_MIN_DELTA;
      fullTurn_q <= `PCS_RST_FULL_TURN;
      irqEn_q    <= {`PCS_IRQ_BITS{1'b0}};
      for (j = 0; j < `PCS_LIM_COUNT; j = j + 1)
        stage_q[j] <= `PCS_RST_LIM;
    end else if (wrEn) begin
      case (addr_q)
        `PCS_OFF_CTRL:      ctrl_q     <= hwdata[1:0];
        `PCS_OFF_IRQ_EN:    irqEn_q    <= hwdata[`PCS_IRQ_BITS-1:0];
        `PCS_OFF_JITTER:    jitter_q   <= hwdata[W-1:0];
        `PCS_OFF_STILL_CYC: stillCyc_q <= hwdata[W-1:0];
        `PCS_OFF_MOVE_CYC:  moveCyc_q  <= hwdata[W-1:0];
        `PCS_OFF_START_CYC: startCyc_q <= hwdata[W-1:0];
        `PCS_OFF_MIN_DELTA: minDelta_q <= hwdata[W-1:0];
        `PCS_OFF_FULL_TURN: fullTurn_q <= hwdata[W-1:0];
        default: begin
          if (limHit)
            stage_q[limIdx] <= hwdata[W-1:0];
        end
      endcase
    end
  end

  // Setup mode: staged limits become the working set of the mode
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `PCS_LIM_COUNT; i = i + 1)
        lim_q[i] <= `PCS_RST_LIM;
    end else if (setupIn) begin
      for (i = 0; i < `PCS_LIM_COUNT; i = i + 1) begin
        if (excentric && (i != `PCS_LIM_TOP_LOW2) &&
            (i != `PCS_LIM_TOP_HIGH2))
          lim_q[i] <= stage_q[i];
        if (pendulum && (i != `PCS_LIM_LATEST))
          lim_q[i] <= stage_q[i];
      end
    end
  end

  wire [W-1:0] topLow1  = lim_q[`PCS_LIM_TOP_LOW1];
  wire [W-1:0] topHigh1 = lim_q[`PCS_LIM_TOP_HIGH1];
  wire [W-1:0] topLow2  = lim_q[`PCS_LIM_TOP_LOW2];
  wire [W-1:0] topHigh2 = lim_q[`PCS_LIM_TOP_HIGH2];
  wire [W-1:0] botLow   = lim_q[`PCS_LIM_BOT_LOW];
  wire [W-1:0] botHigh  = lim_q[`PCS_LIM_BOT_HIGH];
  wire [W-1:0] latest   = lim_q[`PCS_LIM_LATEST];

  // Standstill and direction over one standstill window
  reg [W-1:0] stillCnt_q, stillRef_q;
  wire [W:0]  stillDelta = turnDelta(pos_q, stillRef_q, fullTurn_q);
  wire        stillEnd   = (stillCnt_q == {W{1'b0}});
  wire        bigStep    = stillDelta[W-1:0] > jitter_q;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stillCnt_q        <= {W{1'b0}};
      stillRef_q        <= {W{1'b0}};
      standstillFlag    <= 1'b0;
      forwardMotionFlag <= 1'b0;
      reverseMotionFlag <= 1'b0;
    end else if (stillEnd) begin
      stillCnt_q        <= stillCyc_q - {{W-1{1'b0}}, 1'b1};
      stillRef_q        <= pos_q;
      standstillFlag    <= ~bigStep;
      forwardMotionFlag <= bigStep & ~stillDelta[W];
      reverseMotionFlag <= bigStep & stillDelta[W];
    end else begin
      stillCnt_q <= stillCnt_q - {{W-1{1'b0}}, 1'b1};
    end
  end

  // Motion detection and start timer, only while run is requested
  reg [W-1:0] moveCnt_q, moveRef_q, startCnt_q;
  reg         motion_q, timing_q;
  wire [W:0]  moveDelta = turnDelta(pos_q, moveRef_q, fullTurn_q);
  wire        moveEnd   = (moveCnt_q == {W{1'b0}});
  wire        moveHit   = moveEnd && (moveDelta[W-1:0] > minDelta_q);
  wire        timeout   = timing_q && runReq && !motion_q &&
                          (startCnt_q == {W{1'b0}});

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      moveCnt_q  <= {W{1'b0}};
      moveRef_q  <= {W{1'b0}};
      motion_q   <= 1'b0;
      startCnt_q <= {W{1'b0}};
      timing_q   <= 1'b0;
    end else begin
      if (!runReq || runRise || moveEnd) begin
        moveCnt_q <= moveCyc_q - {{W-1{1'b0}}, 1'b1};
        moveRef_q <= pos_q;
      end else begin
        moveCnt_q <= moveCnt_q - {{W-1{1'b0}}, 1'b1};
      end
      if (!runReq || runRise)
        motion_q <= 1'b0;
      else if (moveHit)
        motion_q <= 1'b1;
      if (runRise) begin
        startCnt_q <= startCyc_q;
        timing_q   <= 1'b1;
      end else if (!runReq || timeout || motion_q) begin
        timing_q <= 1'b0;
      end else if (startCnt_q != {W{1'b0}}) begin
        startCnt_q <= startCnt_q - {{W-1{1'b0}}, 1'b1};
      end
    end
  end

  // Overrun beyond latest stop while coasting in excentric mode
  wire overStop = excentric && !runReq && !standstillFlag &&
                  inWin(pos_q, latest, botLow);
  wire posBad   = ({1'b0, pos_q} > {1'b0, fullTurn_q});
  wire fault    = timeout | overStop | posBad;

  // Window flags, distances and monitor state
  reg [W-1:0] stopLatch_q;
  reg         armed_q;
  wire topHit = inWin(pos_q, topLow1, topHigh1) ||
                (pendulum && inWin(pos_q, topLow2, topHigh2));

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      topDeadCentreFlag    <= 1'b0;
      bottomDeadCentreFlag <= 1'b0;
      upwardStrokeFlag     <= 1'b0;
      topOverrunDistance   <= {W{1'b0}};
      stopOverrunDistance  <= {W{1'b0}};
      stopLatch_q          <= {W{1'b0}};
      armed_q              <= 1'b0;
      monitorOk            <= 1'b0;
    end else begin
      topDeadCentreFlag    <= topHit;
      bottomDeadCentreFlag <= inWin(pos_q, botLow, botHigh);
      upwardStrokeFlag     <= (pos_q >= botHigh);
      topOverrunDistance   <= topLow1 - pos_q;
      if (runFall)
        stopLatch_q <= pos_q;
      stopOverrunDistance  <= (runFall ? pos_q : stopLatch_q) - pos_q;
      // A fresh reset fall rearms; a fault in the same cycle still wins
      if (fault)
        armed_q <= 1'b0;
      else if (rstFall)
        armed_q <= 1'b1;
      monitorOk <= armed_q & ~fault;
    end
  end

  // Interrupt status: set wins over a simultaneous clear
  always @* begin
    irqEvt = {`PCS_IRQ_BITS{1'b0}};
    irqEvt[`PCS_IRQ_TIMEOUT] = timeout;
    irqEvt[`PCS_IRQ_MOTION]  = moveHit & runReq;
    irqEvt[`PCS_IRQ_STILL]   = stillEnd & ~bigStep & ~standstillFlag;
    irqEvt[`PCS_IRQ_REVERSE] = stillEnd & bigStep & stillDelta[W];
    irqEvt[`PCS_IRQ_FAULT]   = fault & armed_q;
    irqClr = {`PCS_IRQ_BITS{1'b0}};
    if (wrEn && (addr_q == `PCS_OFF_IRQ_CLR))
      irqClr = hwdata[`PCS_IRQ_BITS-1:0];
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irqSts_q <= {`PCS_IRQ_BITS{1'b0}};
      irq      <= 1'b0;
    end else begin
      irqSts_q <= (irqSts_q & ~irqClr) | irqEvt;
      irq      <= |(((irqSts_q & ~irqClr) | irqEvt) & irqEn_q);
    end
  end

  // Read data, registered in the wait state
  wire [7:0] status = {motion_q, reverseMotionFlag, forwardMotionFlag,
                       standstillFlag, upwardStrokeFlag,
                       bottomDeadCentreFlag, topDeadCentreFlag, monitorOk};
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (rdPend_q) begin
      hrdata <= 32'h00000000;
      case (addr_q)
        `PCS_OFF_CTRL:      hrdata[1:0] <= ctrl_q;
        `PCS_OFF_STATUS:    hrdata[7:0] <= status;
        `PCS_OFF_IRQ_STS:   hrdata[`PCS_IRQ_BITS-1:0] <= irqSts_q;
        `PCS_OFF_IRQ_EN:    hrdata[`PCS_IRQ_BITS-1:0] <= irqEn_q;
        `PCS_OFF_JITTER:    hrdata[W-1:0] <= jitter_q;
        `PCS_OFF_STILL_CYC: hrdata[W-1:0] <= stillCyc_q;
        `PCS_OFF_MOVE_CYC:  hrdata[W-1:0] <= moveCyc_q;
        `PCS_OFF_START_CYC: hrdata[W-1:0] <= startCyc_q;
        `PCS_OFF_MIN_DELTA: hrdata[W-1:0] <= minDelta_q;
        `PCS_OFF_FULL_TURN: hrdata[W-1:0] <= fullTurn_q;
        `PCS_OFF_TOP_OVR:   hrdata[W-1:0] <= topOverrunDistance;
        `PCS_OFF_STOP_OVR:  hrdata[W-1:0] <= stopOverrunDistance;
        default: begin
          if (limHit)
            hrdata[W-1:0] <= stage_q[limIdx];
        end
      endcase
    end
  end

endmodule

// ### src/pcs_regs.vh
// Register offsets, field positions and reset values of the cam supervisor
`ifndef PCS_REGS_VH
`define PCS_REGS_VH
`define PCS_OFF_CTRL        8'h00
`define PCS_OFF_STATUS      8'h04
`define PCS_OFF_IRQ_STS     8'h08
`define PCS_OFF_IRQ_EN      8'h0C
`define PCS_OFF_IRQ_CLR     8'h10
`define PCS_OFF_JITTER      8'h14
`define PCS_OFF_STILL_CYC   8'h18
`define PCS_OFF_MOVE_CYC    8'h1C
`define PCS_OFF_START_CYC   8'h20
`define PCS_OFF_MIN_DELTA   8'h24
`define PCS_OFF_FULL_TURN   8'h28
`define PCS_OFF_LIM_BASE    8'h2C
`define PCS_OFF_TOP_OVR     8'h48
`define PCS_OFF_STOP_OVR    8'h4C
`define PCS_LIM_COUNT       7
`define PCS_LIM_TOP_LOW1    3'h0
`define PCS_LIM_TOP_HIGH1   3'h1
`define PCS_LIM_TOP_LOW2    3'h2
`define PCS_LIM_TOP_HIGH2   3'h3
`define PCS_LIM_BOT_LOW     3'h4
`define PCS_LIM_BOT_HIGH    3'h5
`define PCS_LIM_LATEST      3'h6
`define PCS_CTRL_PENDULUM   0
`define PCS_CTRL_EXCENTRIC  1
`define PCS_ST_OK           0
`define PCS_ST_TOP          1
`define PCS_ST_BOTTOM       2
`define PCS_ST_UPWARD       3
`define PCS_ST_STILL        4
`define PCS_ST_FORWARD      5
`define PCS_ST_REVERSE      6
`define PCS_ST_MOTION       7
`define PCS_IRQ_TIMEOUT     0
`define PCS_IRQ_MOTION      1
`define PCS_IRQ_STILL       2
`define PCS_IRQ_REVERSE     3
`define PCS_IRQ_FAULT       4
`define PCS_IRQ_BITS        5
`define PCS_RST_CTRL        2'h2
`define PCS_RST_JITTER      16'h0004
`define PCS_RST_STILL_CYC   16'h0064
`define PCS_RST_MOVE_CYC    16'h0064
`define PCS_RST_START_CYC   16'h03E8
`define PCS_RST_MIN_DELTA   16'h0008
`define PCS_RST_FULL_TURN   16'hFFFF
`define PCS_RST_LIM         16'h0000
`endif

// ### verification/pcs_press_cam_supervisor_bench.sv
// Self-checking bench for the press cam supervisor
`timescale 1ns/1ps
`include "pcs_regs.vh"
module pcs_press_cam_supervisor_bench;
  logic        clock, rst, hsel, hwrite, pressRunRequest, camResetIn;
  logic        setupMode, moveEn, loadEn, revAsk;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [15:0] loadVal, stepVal, p;
  wire  [31:0] hrdata;
  wire  [15:0] position, topOverrunDistance, stopOverrunDistance;
  wire         hreadyout, hresp, reversePermission, upwardCamInput;
  wire         overrunCamInput, monitorOk, topDeadCentreFlag, irq;
  wire         bottomDeadCentreFlag, upwardStrokeFlag, forwardMotionFlag;
  wire         reverseMotionFlag, standstillFlag;
  int          fails, checkCount, cyc;
  logic [15:0] lim [7] = '{16'hFC17, 16'h0064, 16'h2000, 16'h2100,
                           16'h7C17, 16'h83E7, 16'h4000};
  logic [15:0] pos [5] = '{16'h0010, 16'h2050, 16'h8000, 16'h9000,
                           16'hFFF0};
  logic [2:0]  flg [5] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h5};
  pcs_press_cam_supervisor #(.W(16)) u_dut (
    .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .position,
    .pressRunRequest, .camResetIn, .setupMode, .reversePermission,
    .upwardCamInput, .overrunCamInput, .monitorOk, .topDeadCentreFlag,
    .bottomDeadCentreFlag, .upwardStrokeFlag, .forwardMotionFlag,
    .reverseMotionFlag, .standstillFlag, .topOverrunDistance,
    .stopOverrunDistance, .irq
  );
  pcs_press_model #(.W(16)) u_enc (
    .clock, .moveEn, .loadEn, .revAsk, .loadVal, .stepVal, .position,
    .upwardCamInput, .overrunCamInput, .reversePermission
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounds every handshake wait as well
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      testDone();
    end
  end
  task automatic chkW(input string n, input logic [31:0] e, g);
    checkCount++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkB(input string n, input logic e, g);
    chkW(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chkW("register", e, rd);
    chkB("hresp", 1'b0, hresp);
  endtask
  task automatic setPos(input logic [15:0] v);
    loadEn <= 1'b1;
    loadVal <= v;
    waitc(1);
    loadEn <= 1'b0;
    waitc(6);
  endtask
  task automatic pulseSetup();
    setupMode <= 1'b1;
    waitc(8);
    setupMode <= 1'b0;
    waitc(8);
  endtask
  // Reset input must rise and fall before each press start
  task automatic arm();
    camResetIn <= 1'b1;
    waitc(4);
    camResetIn <= 1'b0;
    waitc(8);
  endtask
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pressRunRequest = 1'b0;
    camResetIn = 1'b0;
    setupMode = 1'b0;
    moveEn = 1'b0;
    revAsk = 1'b0;
    loadEn = 1'b1;
    loadVal = 16'h0010;
    stepVal = 16'h0000;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    loadEn <= 1'b0;
    rdChk(`PCS_OFF_CTRL, {30'h0, `PCS_RST_CTRL});
    rdChk(`PCS_OFF_JITTER, {16'h0, `PCS_RST_JITTER});
    rdChk(`PCS_OFF_START_CYC, {16'h0, `PCS_RST_START_CYC});
    rdChk(`PCS_OFF_FULL_TURN, {16'h0, `PCS_RST_FULL_TURN});
    rdChk(8'h80, 32'h0);
    wr(`PCS_OFF_STILL_CYC, 32'h8);
    wr(`PCS_OFF_MOVE_CYC, 32'h8);
    wr(`PCS_OFF_START_CYC, 32'h32);
    for (int i = 0; i < 7; i++) wr(8'h2C + 8'(4 * i), {16'h0, lim[i]});
    pulseSetup();
    for (int i = 0; i < 5; i++) begin
      setPos(pos[i]);
      chkW("flags", {29'h0, flg[i]}, {29'h0, topDeadCentreFlag,
        bottomDeadCentreFlag, upwardStrokeFlag});
      chkW("topOvr", {16'h0, 16'hFC17 - pos[i]},
        {16'h0, topOverrunDistance});
    end
    rdChk(`PCS_OFF_TOP_OVR, 32'h0000FC27);
    setPos(16'h0100);
    arm();
    chkB("ok", 1'b1, monitorOk);
    pressRunRequest <= 1'b1;
    stepVal <= 16'h0014;
    moveEn <= 1'b1;
    waitc(40);
    chkB("fwd", 1'b1, forwardMotionFlag);
    chkB("ok", 1'b1, monitorOk);
    xfer(`PCS_OFF_IRQ_STS, 1'b0, 32'h0);
    chkB("motion", 1'b1, rd[`PCS_IRQ_MOTION]);
    moveEn <= 1'b0;
    waitc(30);
    chkB("still", 1'b1, standstillFlag);
    pressRunRequest <= 1'b0;
    waitc(8);
    chkW("stopOvr", 32'h0, {16'h0, stopOverrunDistance});
    p = position;
    setPos(p + 16'h0030);
    chkW("stopOvr", 32'h0000FFD0, {16'h0, stopOverrunDistance});
    revAsk <= 1'b1;
    stepVal <= 16'hFFEC;
    moveEn <= 1'b1;
    waitc(30);
    chkB("rev", 1'b1, reverseMotionFlag);
    moveEn <= 1'b0;
    revAsk <= 1'b0;
    wr(`PCS_OFF_IRQ_CLR, 32'h1F);
    arm();
    pressRunRequest <= 1'b1;
    waitc(1100);
    chkB("ok", 1'b0, monitorOk);
    xfer(`PCS_OFF_IRQ_STS, 1'b0, 32'h0);
    chkB("timeout", 1'b1, rd[`PCS_IRQ_TIMEOUT]);
    chkB("irq", 1'b0, irq);
    wr(`PCS_OFF_IRQ_EN, 32'h1);
    waitc(2);
    chkB("irq", 1'b1, irq);
    wr(`PCS_OFF_IRQ_CLR, 32'h1);
    waitc(2);
    chkB("irq", 1'b0, irq);
    pressRunRequest <= 1'b0;
    arm();
    wr(`PCS_OFF_FULL_TURN, 32'hF000);
    setPos(16'hF800);
    chkB("ok", 1'b0, monitorOk);
    wr(`PCS_OFF_FULL_TURN, 32'hFFFF);
    arm();
    chkB("ok", 1'b1, monitorOk);
    // Coasting past the latest stop while not still drops the monitor
    setPos(16'h5000);
    waitc(8);
    chkB("ok", 1'b0, monitorOk);
    wr(`PCS_OFF_CTRL, 32'h1);
    pulseSetup();
    setPos(16'h2050);
    chkB("top2", 1'b1, topDeadCentreFlag);
    testDone();
  end
endmodule

// ### verification/pcs_press_model.sv
// Press encoder and cam partner model
`timescale 1ns/1ps
module pcs_press_model #(
  parameter W      = 16,
  parameter UP_LO  = 16'h83E7,
  parameter OVR_LO = 16'hFC17
) (
  input  wire          clock,
  input  wire          moveEn,
  input  wire          loadEn,
  input  wire          revAsk,
  input  wire [W-1:0]  loadVal,
  input  wire [W-1:0]  stepVal,
  output logic [W-1:0] position,
  output logic         upwardCamInput,
  output logic         overrunCamInput,
  output logic         reversePermission
);
  initial position = {W{1'b0}};
  // Whole-cycle steps, as the per-bit synchroniser needs
  always @(posedge clock) begin
    if (loadEn) begin
      position <= loadVal;
    end else if (moveEn) begin
      position <= position + stepVal;
    end
  end
  assign upwardCamInput  = position >= UP_LO;
  assign overrunCamInput = position >= OVR_LO;
  // Backward move granted only with both cams clear
  assign reversePermission = revAsk && !upwardCamInput &&
                             !overrunCamInput;
endmodule

// ### verification/pcs_supervisor_chk.sv
// Port-level assertions for the press cam supervisor
`timescale 1ns/1ps
module pcs_supervisor_chk #(
  parameter W = 16
) (
  input wire         clock,
  input wire         rst,
  input wire         hsel,
  input wire [1:0]   htrans,
  input wire         hwrite,
  input wire         hready,
  input wire         hreadyout,
  input wire [W-1:0] position,
  input wire         pressRunRequest,
  input wire         camResetIn,
  input wire         setupMode,
  input wire         monitorOk,
  input wire         forwardMotionFlag,
  input wire         reverseMotionFlag,
  input wire         standstillFlag,
  input wire [W-1:0] topOverrunDistance,
  input wire [W-1:0] stopOverrunDistance
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  reg [3:0]  setupAge_q;
  reg [3:0]  runAge_q;
  reg [3:0]  fallAge_q;
  reg [10:0] runStill_q;
  reg        runMoved_q;
  // Ages saturate so relations apply only well clear of a change
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      setupAge_q <= 4'h0;
      runAge_q   <= 4'h0;
      fallAge_q  <= 4'hF;
      runStill_q <= 11'h000;
      runMoved_q <= 1'b0;
    end else begin
      setupAge_q <= setupMode ? 4'h0 : setupAge_q + 4'(setupAge_q != 4'hF);
      runAge_q   <= (pressRunRequest != $past(pressRunRequest)) ? 4'h0 :
                    runAge_q + 4'(runAge_q != 4'hF);
      fallAge_q  <= (!camResetIn && $past(camResetIn)) ? 4'h0 :
                    fallAge_q + 4'(fallAge_q != 4'hF);
      runStill_q <= !pressRunRequest ? 11'h000 :
                    runStill_q + 11'(runStill_q != 11'h7FF);
      runMoved_q <= pressRunRequest &&
                    (runMoved_q || position != $past(position));
    end
  end
  sequence s_rdreq; hsel && htrans[1] && !hwrite && hready; endsequence
  sequence s_rdans; !hreadyout ##1 hreadyout; endsequence
  property p_rdwait; s_rdreq |=> s_rdans; endproperty
  a_rdwait: assert property (p_rdwait)
    else $error("read wait state wrong");
  property p_wrfast; hsel && htrans[1] && hwrite && hready |=> hreadyout;
  endproperty
  a_wrfast: assert property (p_wrfast)
    else $error("write not zero wait");
  property p_okarm; $rose(monitorOk) |-> fallAge_q <= 4'h6; endproperty
  a_okarm: assert property (p_okarm)
    else $error("monitor ok set without reset fall");
  property p_timeout; runStill_q >= 11'h3FC && !runMoved_q |-> !monitorOk;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("monitor ok kept without motion");
  property p_direx; !(forwardMotionFlag && reverseMotionFlag); endproperty
  a_direx: assert property (p_direx)
    else $error("both directions set");
  property p_stilldir;
    standstillFlag |-> !forwardMotionFlag && !reverseMotionFlag;
  endproperty
  a_stilldir: assert property (p_stilldir)
    else $error("direction set at standstill");
  property p_topovr; setupAge_q == 4'hF |->
    topOverrunDistance - $past(topOverrunDistance) ==
    $past(position, 4) - $past(position, 3);
  endproperty
  a_topovr: assert property (p_topovr)
    else $error("top overrun does not track position");
  property p_stopovr; runAge_q == 4'hF |->
    stopOverrunDistance - $past(stopOverrunDistance) ==
    $past(position, 4) - $past(position, 3);
  endproperty
  a_stopovr: assert property (p_stopovr)
    else $error("stop overrun does not track position");
endmodule
bind pcs_press_cam_supervisor pcs_supervisor_chk #(.W(W)) u_chk (
  .clock, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .position,
  .pressRunRequest, .camResetIn, .setupMode, .monitorOk,
  .forwardMotionFlag, .reverseMotionFlag, .standstillFlag,
  .topOverrunDistance, .stopOverrunDistance
);
